/* hdl/dwd_pkg.sv */
// constants and types for the dac input word decoder
package dwd_pkg;

  // ********************************************************
  // frame layout
  // ********************************************************
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned NUM_CH         = 4;
  localparam int unsigned CH_IDX_W       = 2;
  localparam int unsigned SHIFT_W        = 32;
  localparam int unsigned BITCNT_W       = 6;
  localparam logic [5:0]  FRAME_BITS     = 6'h18;
  localparam logic [5:0]  FRAME_BITS_PEC = 6'h20;
  localparam logic [5:0]  BITCNT_MAX     = 6'h3f;
  localparam int unsigned FRAME_LSB      = 0;
  localparam int unsigned FRAME_LSB_PEC  = 8;

  // ********************************************************
  // register-select codes
  // ********************************************************
  localparam logic [2:0] SEL_OUTPUT_CODE = 3'h0;
  localparam logic [2:0] SEL_GAIN_ONE    = 3'h2;
  localparam logic [2:0] SEL_GAIN_ALL    = 3'h3;
  localparam logic [2:0] SEL_OFFSET_ONE  = 3'h4;
  localparam logic [2:0] SEL_OFFSET_ALL  = 3'h5;
  localparam logic [2:0] SEL_CLEAR_CODE  = 3'h6;
  localparam logic [2:0] SEL_CONTROL     = 3'h7;
  localparam logic       ACCESS_WRITE    = 1'b0;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [15:0] RST_OUTPUT_CODE = 16'h0000;
  localparam logic [15:0] RST_GAIN_TRIM   = 16'hffff;
  localparam logic [15:0] RST_OFFSET_TRIM = 16'h8000;
  localparam logic [15:0] RST_CLEAR_VALUE = 16'h0000;
  localparam logic [15:0] OFFSET_ZERO     = 16'h8000;

  // ********************************************************
  // types
  // ********************************************************
  typedef struct packed {
    logic       read_not_write;
    logic [1:0] device_select;
    logic [2:0] register_select;
    logic [1:0] channel_select;
  } dwd_header_t;

  typedef struct packed {
    dwd_header_t header;
    logic [15:0] payload;
  } dwd_frame_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SHIFT  = 3'b010,
    ST_COMMIT = 3'b100
  } dwd_state_t;

endpackage

/* hdl/dwd_sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dwd_sync2 #(
  parameter int unsigned     WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

/* hdl/dwd_decoder.sv */
// serial input word decoder writing per-channel code, trim and clear registers
// Contract
// RL1 - frame is 24 bits, 32 with check
// RL2 - top bit selects read or write
// RL3 - act only when device bits match straps
// RL4 - code 000 writes one channel's output code
// RL5 - code 110 writes one clear value
// RL6 - code 111 goes to control group
// RL7 - channel field picks A to D
// RL8 - header above, 16-bit payload below
// RL9 - code 010 writes one gain trim
// RL10 - code 011 writes all gain trims
// RL11 - gain trim is straight binary
// RL12 - gain trim resets to all ones
// RL13 - host keeps gain trim near half range; the bench broadcasts a gain trim of 0000
// RL14 - code 100 writes one offset trim
// RL15 - code 101 writes all offset trims
// RL16 - offset resets mid-scale, signed is code minus mid
// RL17 - clear value loads channel on clear
// RL18 - clear value resets to zero
// RL19 - per channel clear enable
// RL20 - foreign device frame changes nothing
// RL21 - only complete framed frames write
`timescale 1ns/1ps
module dwd_decoder
  import dwd_pkg::*;
#(
  parameter int unsigned CHANNELS = dwd_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic                              i_clock,
  input  wire logic                              i_rst_n,
  // serial link pins
  input  wire logic                              i_serial_clock,
  input  wire logic                              i_frame_sync_n,
  input  wire logic                              i_serial_data,
  // strap and clear pins
  input  wire logic                              i_strap_pin_high,
  input  wire logic                              i_strap_pin_low,
  input  wire logic                              i_clear,
  // configuration from control logic
  input  wire logic                              i_packet_error_check_en,
  input  wire logic [CHANNELS-1:0]               i_clear_enable,
  // per-channel register contents
  output logic      [CHANNELS-1:0][DATA_W-1:0]   o_channel_output_code,
  output logic      [CHANNELS-1:0][DATA_W-1:0]   o_channel_gain_trim,
  output logic      [CHANNELS-1:0][DATA_W-1:0]   o_channel_offset_trim,
  output logic      [CHANNELS-1:0][DATA_W-1:0]   o_channel_offset_signed,
  output logic      [CHANNELS-1:0][DATA_W-1:0]   o_channel_clear_value,
  // control group hand-off
  output logic                                   o_control_valid,
  output dwd_pkg::dwd_frame_t                    o_control_frame
);

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  logic [4:0] pins_sync;
  logic       sclk_s;
  logic       sync_n_s;
  logic       sdata_s;
  logic [1:0] strap_s;
  logic       clear_s;
  // sync_n (bit 3) idles high so a reset does not fake a frame start
  dwd_sync2 #(
    .WIDTH   (5),
    .RST_VAL (5'h08)
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({i_serial_clock, i_frame_sync_n, i_serial_data,
               i_strap_pin_high, i_strap_pin_low}),
    .o_sync  (pins_sync)
  );
  dwd_sync2 #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_clear_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async (i_clear),
    .o_sync  (clear_s)
  );
  assign sclk_s   = pins_sync[4];
  assign sync_n_s = pins_sync[3];
  assign sdata_s  = pins_sync[2];
  assign strap_s  = pins_sync[1:0];

  // ********************************************************
  // edge detection
  // ********************************************************
  logic sclk_prev_r;
  logic sclk_prev_nxt;
  logic sync_prev_r;
  logic sync_prev_nxt;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  always_comb
  begin
    sclk_prev_nxt = sclk_s;
    sync_prev_nxt = sync_n_s;
  end
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      sclk_prev_r <= 1'b0;
      sync_prev_r <= 1'b1;
    end
    else
    begin
      sclk_prev_r <= sclk_prev_nxt;
      sync_prev_r <= sync_prev_nxt;
    end
  end
  // data is taken on the falling serial clock edge
  assign sclk_fall = sclk_prev_r & ~sclk_s;
  assign sync_fall = sync_prev_r & ~sync_n_s;
  assign sync_rise = ~sync_prev_r & sync_n_s;

  // ********************************************************
  // frame shifter and state
  // ********************************************************
  dwd_state_t           state_r;
  dwd_state_t           state_nxt;
  logic [SHIFT_W-1:0]   shift_r;
  logic [SHIFT_W-1:0]   shift_nxt;
  logic [BITCNT_W-1:0]  bitcnt_r;
  logic [BITCNT_W-1:0]  bitcnt_nxt;
  logic [BITCNT_W-1:0]  frame_len;
  dwd_frame_t           frame;
  logic                 frame_ok;
  // RL1 frame length select
  assign frame_len = i_packet_error_check_en ? FRAME_BITS_PEC : FRAME_BITS;
  // RL8 header and payload split
  // check byte trails the word and is dropped
  assign frame = i_packet_error_check_en ? dwd_frame_t'(shift_r[FRAME_LSB_PEC +: 24])
                                         : dwd_frame_t'(shift_r[FRAME_LSB +: 24]);
  // RL21 exact length only
  assign frame_ok = (bitcnt_r == frame_len);
  always_comb
  begin
    state_nxt  = state_r;
    shift_nxt  = shift_r;
    bitcnt_nxt = bitcnt_r;
    case (state_r)
      ST_IDLE:
      begin
        if (sync_fall)
        begin
          state_nxt  = ST_SHIFT;
          bitcnt_nxt = '0;
        end
      end
      ST_SHIFT:
      begin
        if (sync_rise)
        begin
          // RL21 partial frame dropped
          state_nxt = frame_ok ? ST_COMMIT : ST_IDLE;
        end
        else if (sclk_fall)
        begin
          shift_nxt = {shift_r[SHIFT_W-2:0], sdata_s};
          if (bitcnt_r != BITCNT_MAX)
          begin
            bitcnt_nxt = bitcnt_r + 6'h01;
          end
        end
      end
      // commit lasts one cycle; stray codes recover the same way
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_r  <= ST_IDLE;
      shift_r  <= '0;
      bitcnt_r <= '0;
    end
    else
    begin
      state_r  <= state_nxt;
      shift_r  <= shift_nxt;
      bitcnt_r <= bitcnt_nxt;
    end
  end

  // ********************************************************
  // header decode
  // ********************************************************
  logic commit;
  logic wr_ok;
  logic wr_output;
  logic wr_gain_one;
  logic wr_gain_all;
  logic wr_offset_one;
  logic wr_offset_all;
  logic wr_clear;
  logic wr_control;
  // RL3 strap match
  // RL20 foreign frames ignored
  // RL2 reads not served here
  assign commit = (state_r == ST_COMMIT);
  assign wr_ok  = commit
                  && (frame.header.device_select == strap_s)
                  && (frame.header.read_not_write == ACCESS_WRITE);
  always_comb
  begin
    wr_output     = 1'b0;
    wr_gain_one   = 1'b0;
    wr_gain_all   = 1'b0;
    wr_offset_one = 1'b0;
    wr_offset_all = 1'b0;
    wr_clear      = 1'b0;
    wr_control    = 1'b0;
    if (frame.header.register_select == SEL_OUTPUT_CODE)
    begin
      wr_output = wr_ok;
    end
    else if (frame.header.register_select == SEL_GAIN_ONE)
    begin
      wr_gain_one = wr_ok;
    end
    else if (frame.header.register_select == SEL_GAIN_ALL)
    begin
      wr_gain_all = wr_ok;
    end
    else if (frame.header.register_select == SEL_OFFSET_ONE)
    begin
      wr_offset_one = wr_ok;
    end
    else if (frame.header.register_select == SEL_OFFSET_ALL)
    begin
      wr_offset_all = wr_ok;
    end
    else if (frame.header.register_select == SEL_CLEAR_CODE)
    begin
      wr_clear = wr_ok;
    end
    else if (frame.header.register_select == SEL_CONTROL)
    begin
      wr_control = wr_ok;
    end
  end

  // ********************************************************
  // control group hand-off
  // ********************************************************
  logic       ctrl_valid_r;
  logic       ctrl_valid_nxt;
  dwd_frame_t ctrl_frame_r;
  dwd_frame_t ctrl_frame_nxt;
  // RL6 control frames forwarded
  always_comb
  begin
    ctrl_valid_nxt = wr_control;
    ctrl_frame_nxt = wr_control ? frame : ctrl_frame_r;
  end
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      ctrl_valid_r <= 1'b0;
      ctrl_frame_r <= '0;
    end
    else
    begin
      ctrl_valid_r <= ctrl_valid_nxt;
      ctrl_frame_r <= ctrl_frame_nxt;
    end
  end
  assign o_control_valid = ctrl_valid_r;
  assign o_control_frame = ctrl_frame_r;

  // ********************************************************
  // per-channel registers
  // ********************************************************
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_ch
      logic [DATA_W-1:0] code_r;
      logic [DATA_W-1:0] code_nxt;
      logic [DATA_W-1:0] gain_r;
      logic [DATA_W-1:0] gain_nxt;
      logic [DATA_W-1:0] offset_r;
      logic [DATA_W-1:0] offset_nxt;
      logic [DATA_W-1:0] clear_r;
      logic [DATA_W-1:0] clear_nxt;
      logic              hit;

      // RL7 channel select
      assign hit = (frame.header.channel_select == CH_IDX_W'(ch));

      always_comb
      begin
        code_nxt   = code_r;
        gain_nxt   = gain_r;
        offset_nxt = offset_r;
        clear_nxt  = clear_r;
        // RL4 output code write
        if (wr_output && hit)
        begin
          code_nxt = frame.payload;
        end
        // RL9 single gain write
        // RL10 broadcast gain write
        // RL11 stored as straight binary
        if ((wr_gain_one && hit) || wr_gain_all)
        begin
          gain_nxt = frame.payload;
        end
        // RL14 single offset write
        // RL15 broadcast offset write
        if ((wr_offset_one && hit) || wr_offset_all)
        begin
          offset_nxt = frame.payload;
        end
        // RL5 clear value write
        if (wr_clear && hit)
        begin
          clear_nxt = frame.payload;
        end
        // RL17 clear loads channel
        // RL19 only enabled channels
        // clear wins over a same-cycle code write, as the pin overrides
        if (clear_s && i_clear_enable[ch])
        begin
          code_nxt = clear_r;
        end
      end

      // RL12 gain resets full scale
      // RL16 offset resets mid-scale
      // RL18 clear value resets zero
      always_ff @(posedge i_clock)
      begin
        if (!i_rst_n)
        begin
          code_r   <= RST_OUTPUT_CODE;
          gain_r   <= RST_GAIN_TRIM;
          offset_r <= RST_OFFSET_TRIM;
          clear_r  <= RST_CLEAR_VALUE;
        end
        else
        begin
          code_r   <= code_nxt;
          gain_r   <= gain_nxt;
          offset_r <= offset_nxt;
          clear_r  <= clear_nxt;
        end
      end

      assign o_channel_output_code[ch] = code_r;
      assign o_channel_gain_trim[ch]   = gain_r;
      assign o_channel_offset_trim[ch] = offset_r;
      assign o_channel_clear_value[ch] = clear_r;
      // RL16 signed offset view
      // two's complement wrap gives code minus mid-scale
      assign o_channel_offset_signed[ch] = offset_r - OFFSET_ZERO;
    end

endmodule

/* testbench/dwd_decoder_props.sv */
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module dwd_decoder_props
  import dwd_pkg::*;
#(
  parameter int unsigned CHANNELS = 4
) (
  // clock and reset
  input wire logic                            i_clock,
  input wire logic                            i_rst_n,
  // design inputs
  input wire logic                            i_serial_clock,
  input wire logic                            i_frame_sync_n,
  input wire logic                            i_serial_data,
  input wire logic                            i_strap_pin_high,
  input wire logic                            i_strap_pin_low,
  input wire logic                            i_clear,
  input wire logic                            i_packet_error_check_en,
  input wire logic [CHANNELS-1:0]             i_clear_enable,
  // design outputs
  input wire logic [CHANNELS-1:0][DATA_W-1:0] o_channel_output_code,
  input wire logic [CHANNELS-1:0][DATA_W-1:0] o_channel_gain_trim,
  input wire logic [CHANNELS-1:0][DATA_W-1:0] o_channel_offset_trim,
  input wire logic [CHANNELS-1:0][DATA_W-1:0] o_channel_offset_signed,
  input wire logic [CHANNELS-1:0][DATA_W-1:0] o_channel_clear_value,
  input wire logic                            o_control_valid,
  input wire dwd_pkg::dwd_frame_t             o_control_frame
);
  // ********************************************************
  // cycles since the frame pin last rose
  // ********************************************************
  logic       fs_r;
  logic [3:0] since_r;
  logic [3:0] since_nxt;
  always_comb
  begin
    since_nxt = (since_r == 4'hf) ? since_r : since_r + 4'h1;
    if (!fs_r && i_frame_sync_n)
      since_nxt = 4'h0;
  end
  // saturates so long idle gaps stay above the commit window
  always_ff @(posedge i_clock)
  begin
    fs_r    <= i_rst_n ? i_frame_sync_n : 1'b1;
    since_r <= i_rst_n ? since_nxt : 4'hf;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ********************************************************
  // assertions
  // ********************************************************
  a_reset_values: assert property ($rose(i_rst_n) |-> o_channel_gain_trim == '1
    && o_channel_offset_trim == {CHANNELS{RST_OFFSET_TRIM}} && o_channel_clear_value == '0)
    else $error("reset values wrong");
  a_commit_late: assert property ($changed({o_channel_gain_trim, o_channel_offset_trim,
    o_channel_clear_value}) |-> since_r <= 4'ha) else $error("write outside commit window");
  a_control_pulse: assert property (o_control_valid |-> since_r <= 4'ha ##1 !o_control_valid)
    else $error("control pulse wrong");
  a_control_frame: assert property (o_control_valid |-> o_control_frame.header.register_select
    == SEL_CONTROL && o_control_frame.header.read_not_write == ACCESS_WRITE
    && o_control_frame.header.device_select == {i_strap_pin_high, i_strap_pin_low})
    else $error("control frame header wrong");
  a_frame_held: assert property ($changed(o_control_frame) |-> o_control_valid)
    else $error("control frame changed without pulse");
  for (genvar n = 0; n < CHANNELS; n++)
  begin : g_ch
    sequence s_clear_held;
      (i_clear && i_clear_enable[n]) [*5];
    endsequence
    sequence s_masked;
      (!i_clear_enable[n] && since_r > 4'ha) [*4];
    endsequence
    a_signed_offset: assert property (o_channel_offset_signed[n]
      == o_channel_offset_trim[n] - OFFSET_ZERO) else $error("signed offset wrong");
    a_clear_loads: assert property (s_clear_held |->
      o_channel_output_code[n] == o_channel_clear_value[n]) else $error("clear not applied");
    a_clear_masked: assert property (s_masked |-> $stable(o_channel_output_code[n]))
      else $error("disabled channel changed");
  end
endmodule
bind dwd_decoder dwd_decoder_props #(.CHANNELS(CHANNELS)) u_props (.*);

/* testbench/dwd_host_model.sv */
// host side of the serial link
`timescale 1ns/1ps
module dwd_host_model (
  // clock
  input  wire logic i_clock,
  // link pins
  output logic      o_sclk,
  output logic      o_fs_n,
  output logic      o_sdata
);
  initial
  begin
    o_sclk  = 1'b0;
    o_fs_n  = 1'b1;
    o_sdata = 1'b0;
  end
  task automatic send(input logic [31:0] w, input int n);
    o_fs_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clock);
      o_sclk  <= 1'b1;
      o_sdata <= w[31-i];
      repeat (4) @(posedge i_clock);
      o_sclk <= 1'b0;
      // four clocks low plus the next bit's wait, five in all: a 180 ns link period
      repeat (4) @(posedge i_clock);
    end
    repeat (2) @(posedge i_clock);
    o_fs_n  <= 1'b1;
    // released data line must not look held
    o_sdata <= ~o_sdata;
    repeat (10) @(posedge i_clock);
  endtask
endmodule

/* testbench/dwd_decoder_tb.sv */
// self-checking bench for the input word decoder
`timescale 1ns/1ps
module dwd_decoder_tb;
  import dwd_pkg::*;
  // ********************************************************
  // signals
  // ********************************************************
  logic             i_clock, i_rst_n, sclk, fs_n, sdata, i_clear, pec_en, ctl_v;
  logic [3:0]       clr_en;
  logic [1:0]       strap;
  logic [3:0][15:0] code, gain, off, offs, clrv;
  dwd_frame_t       ctl_f;
  logic [15:0]      e_code[4], e_gain[4], e_off[4], e_clr[4];
  int               bad_count, check_count, ctl_n;
  dwd_host_model host (.i_clock(i_clock), .o_sclk(sclk), .o_fs_n(fs_n), .o_sdata(sdata));
  dwd_decoder uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_serial_clock(sclk),
    .i_frame_sync_n(fs_n), .i_serial_data(sdata), .i_strap_pin_high(strap[1]),
    .i_strap_pin_low(strap[0]), .i_clear(i_clear), .i_packet_error_check_en(pec_en),
    .i_clear_enable(clr_en), .o_channel_output_code(code), .o_channel_gain_trim(gain),
    .o_channel_offset_trim(off), .o_channel_offset_signed(offs),
    .o_channel_clear_value(clrv), .o_control_valid(ctl_v), .o_control_frame(ctl_f));
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  always @(negedge i_clock)
    if (ctl_v === 1'b1)
      ctl_n++;
  // ********************************************************
  // helpers
  // ********************************************************
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_all;
    for (int c = 0; c < 4; c++)
    begin
      cmp(code[c], e_code[c]);
      cmp(gain[c], e_gain[c]);
      cmp(off[c], e_off[c]);
      cmp(offs[c], e_off[c] - 16'h8000);
      cmp(clrv[c], e_clr[c]);
    end
  endtask
  task automatic wr(input logic rw, input logic [1:0] dev, input logic [2:0] sel,
    input logic [1:0] ch, input logic [15:0] d, input int n);
    host.send({rw, dev, sel, ch, d, 8'h5a}, n);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset;
    for (int c = 0; c < 4; c++)
    begin
      e_code[c] = 16'h0000;
      e_gain[c] = 16'hffff;
      e_off[c]  = 16'h8000;
      e_clr[c]  = 16'h0000;
    end
    check_all;
  endtask
  task automatic t_single;
    logic [2:0]  sels[4] = '{SEL_OUTPUT_CODE, SEL_GAIN_ONE, SEL_OFFSET_ONE, SEL_CLEAR_CODE};
    logic [15:0] d;
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 4; c++)
      begin
        d = {4'(s), 4'(c), 8'ha5};
        wr(ACCESS_WRITE, strap, sels[s], 2'(c), d, 24);
        case (s)
          0: e_code[c] = d;
          1: e_gain[c] = d;
          2: e_off[c] = d;
          default: e_clr[c] = d;
        endcase
        check_all;
      end
  endtask
  task automatic t_broadcast;
    wr(ACCESS_WRITE, strap, SEL_GAIN_ALL, 2'h1, 16'h0000, 24);
    wr(ACCESS_WRITE, strap, SEL_OFFSET_ALL, 2'h2, 16'hffff, 24);
    for (int c = 0; c < 4; c++)
    begin
      e_gain[c] = 16'h0000;
      e_off[c]  = 16'hffff;
    end
    check_all;
  endtask
  task automatic t_refused;
    wr(ACCESS_WRITE, ~strap, SEL_GAIN_ONE, 2'h0, 16'h1234, 24);
    wr(1'b1, strap, SEL_OUTPUT_CODE, 2'h0, 16'h4321, 24);
    wr(ACCESS_WRITE, strap, SEL_CLEAR_CODE, 2'h1, 16'h7777, 23);
    wr(ACCESS_WRITE, strap, SEL_CLEAR_CODE, 2'h1, 16'h7777, 25);
    pec_en <= 1'b1;
    wr(ACCESS_WRITE, strap, SEL_OFFSET_ONE, 2'h3, 16'h0000, 32);
    wr(ACCESS_WRITE, strap, SEL_OFFSET_ONE, 2'h2, 16'h1111, 24);
    pec_en <= 1'b0;
    e_off[3] = 16'h0000;
    check_all;
  endtask
  task automatic t_control;
    int n0;
    n0 = ctl_n;
    wr(ACCESS_WRITE, strap, SEL_CONTROL, 2'h3, 16'h2abc, 24);
    cmp(16'(ctl_n - n0), 16'h0001);
    cmp(ctl_f.payload, 16'h2abc);
    cmp({8'h00, ctl_f.header}, {8'h00, ACCESS_WRITE, strap, SEL_CONTROL, 2'h3});
    check_all;
  endtask
  task automatic t_clear;
    clr_en  <= 4'b0101;
    i_clear <= 1'b1;
    repeat (10) @(posedge i_clock);
    e_code[0] = e_clr[0];
    e_code[2] = e_clr[2];
    check_all;
    // code keeps the clear value once the pin drops
    i_clear <= 1'b0;
    repeat (10) @(posedge i_clock);
    check_all;
  endtask
  // ********************************************************
  // main sequence and watchdog
  // ********************************************************
  initial
  begin
    i_rst_n = 1'b0;
    i_clear = 1'b0;
    pec_en  = 1'b0;
    clr_en  = 4'h0;
    strap   = 2'h2;
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    t_reset();
    t_single();
    t_broadcast();
    t_refused();
    t_control();
    t_clear();
    print_verdict();
  end
  // about 25 frames of some 230 cycles each
  initial
  begin
    repeat (40000) @(posedge i_clock);
    bad_count++;
    print_verdict();
  end
endmodule
